// file: bench/spfm_remote.sv
`timescale 1ns/1ps
module spfm_remote (
  input  wire logic linkClk,
  input  wire logic txd,
  input  wire logic pinIn,
  output logic      lineOut
);
  // ********************************************************
  // remote shift register and serial transceiver
  // ********************************************************
  localparam int BIT_LINK = 32;
  logic       m0;
  logic [7:0] tx0;
  logic [7:0] rx0;
  initial begin
    lineOut = 1'b1;
    m0 = 1'b1;
    tx0 = 8'h00;
    rx0 = 8'h00;
  end
  // data moves on falling clock, filler keeps changing
  always @(negedge txd) if (m0) begin
    lineOut <= tx0[0];
    tx0 <= {~tx0[0], tx0[7:1]};
  end
  always @(posedge txd) if (m0) rx0 <= {pinIn, rx0[7:1]};
  task automatic sendAsync(input logic [10:0] bits, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      repeat (len) @(posedge linkClk);
    end
    lineOut <= 1'b1;
    // idle high so the next start edge is seen
    repeat (len) @(posedge linkClk);
  endtask : sendAsync
  task automatic recvAsync(input int n, output logic [10:0] bits);
    bits = 11'h000;
    @(negedge txd);
    repeat (BIT_LINK / 2) @(posedge linkClk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (BIT_LINK) @(posedge linkClk);
    end
  endtask : recvAsync
endmodule : spfm_remote

// file: bench/spfm_sva.sv
`timescale 1ns/1ps
module spfm_sva
  import spfm_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          reset,
  input wire spfm_apb_req_t apbReq,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  input wire logic          rxdIn,
  input wire logic          rxdOut,
  input wire logic          rxdOe,
  input wire logic          txd
);
  // ********************************************************
  // mode and bit length seen on the register bus
  // ********************************************************
  logic [1:0]  seenMode_reg;
  logic [16:0] baud_reg;
  logic [20:0] lowRun_reg;
  logic [16:0] nPlus;
  logic [20:0] bitLen;
  logic        wrDone;
  logic        mapped;
  assign wrDone = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
  assign mapped = apbReq.paddr inside {OFS_CONTROL, OFS_BUFFER, OFS_BAUD};
  assign nPlus  = {1'b0, baud_reg[15:0]} + 17'h00001;
  assign bitLen = (seenMode_reg == 2'h2) ? (baud_reg[BIT_BAUD_FAST] ? 21'h10 : 21'h20)
                                         : {nPlus, 4'h0};
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seenMode_reg <= 2'h0;
      baud_reg     <= 17'h00000;
      lowRun_reg   <= 21'h000000;
    end else begin
      lowRun_reg <= txd ? 21'h000000 : lowRun_reg + 21'h000001;
      if (wrDone && apbReq.paddr == OFS_CONTROL) seenMode_reg <= apbReq.pwdata[7:6];
      if (wrDone && apbReq.paddr == OFS_BAUD) baud_reg <= apbReq.pwdata[16:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_ready_wait: assert property (apbReq.psel && !apbReq.penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without pslverr");
  chk_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access with pslverr");
  chk_err_rdzero: assert property (pready && pslverr && !apbReq.pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_clk_low: assert property (seenMode_reg == 2'h0 && $fell(txd) |-> !txd [*6] ##1 txd)
    else $error("shift clock low span wrong");
  chk_clk_high: assert property (seenMode_reg == 2'h0 && $rose(txd) |-> txd [*6])
    else $error("shift clock high span wrong");
  chk_data_steady: assert property (rxdOe && !txd && !$past(txd) |-> $stable(rxdOut))
    else $error("data moved while shift clock low");
  chk_pin_idle: assert property (!rxdOe |-> rxdOut)
    else $error("released data pin not high");
  chk_async_nodrive: assert property (seenMode_reg != 2'h0 |-> !rxdOe)
    else $error("data pin driven in async mode");
  chk_bit_multiple: assert property (seenMode_reg != 2'h0 && $rose(txd) |->
    lowRun_reg % bitLen == 21'h0)
    else $error("low run not whole bit times");
  cover property ($rose(rxdOe));
  cover property (seenMode_reg != 2'h0 && $fell(txd));
  cover property (pready && pslverr);
endmodule : spfm_sva

bind spfm_top spfm_sva u_sva (.core_clk(core_clk), .reset(reset), .apbReq(apbReq),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxdIn(rxdIn), .rxdOut(rxdOut),
  .rxdOe(rxdOe), .txd(txd));

// file: bench/test_spfm_top.sv
`timescale 1ns/1ps
module test_spfm_top
  import spfm_pkg::*;
();
  // ********************************************************
  // bench
  // ********************************************************
  logic          core_clk;
  logic          reset;
  logic          linkClk;
  spfm_apb_req_t apbReq;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic          rxdOut;
  logic          rxdOe;
  logic          txd;
  logic          lineOut;
  logic          pin;
  int            errCount;
  int            nChecks;
  assign pin = rxdOe ? rxdOut : lineOut;
  spfm_top DUT (.core_clk(core_clk), .reset(reset), .apbReq(apbReq), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rxdIn(pin), .rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd));
  spfm_remote rm (.linkClk(linkClk), .txd(txd), .pinIn(pin), .lineOut(lineOut));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #37;
    forever #62.5 linkClk = ~linkClk;
  end
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : printVerdict
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdata, output logic err);
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdata = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdCheck(input logic [31:0] a, input string what, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    compare(what, exp, r);
  endtask : rdCheck
  task automatic waitFlag(input int b);
    logic [31:0] c;
    logic        e;
    c = 32'h0;
    while (c[b] !== 1'b1) apb(1'b0, OFS_CONTROL, 32'h0, c, e);
  endtask : waitFlag
  task automatic testRegs();
    logic [31:0] d;
    logic        e;
    rdCheck(OFS_CONTROL, "control reset", 32'h0);
    apb(1'b0, 32'h0000_000c, 32'h0, d, e);
    compare("unmapped error", 32'h1, {31'h0, e});
    compare("unmapped data", 32'h0, d);
    wr(OFS_BAUD, 32'h0000_0018);
    rdCheck(OFS_BAUD, "baud", 32'h18);
    $display("regs done");
  endtask : testRegs
  task automatic testShift();
    wr(OFS_BUFFER, 32'h0000_00a5);
    waitFlag(BIT_TX_FLAG);
    compare("shift out byte", 32'ha5, {24'h0, rm.rx0});
    rm.tx0 = 8'h3c;
    wr(OFS_CONTROL, 32'h0000_0010);
    waitFlag(BIT_RX_FLAG);
    rdCheck(OFS_BUFFER, "shift in byte", 32'h3c);
    $display("shift mode done");
  endtask : testShift
  task automatic testTen();
    logic [10:0] f;
    rm.m0 = 1'b0;
    rm.lineOut = 1'b1;
    wr(OFS_CONTROL, 32'h0000_0040);
    fork
      wr(OFS_BUFFER, 32'h0000_005a);
      rm.recvAsync(10, f);
    join
    compare("ten bit frame", 32'h2b4, {21'h0, f});
    rdCheck(OFS_CONTROL, "tx flag", 32'h42);
    wr(OFS_CONTROL, 32'h0000_0070);
    rm.sendAsync(11'h0aa, 10, 32);
    rdCheck(OFS_CONTROL, "low stop dropped", 32'h70);
    rm.sendAsync(11'h386, 10, 32);
    waitFlag(BIT_RX_FLAG);
    rdCheck(OFS_BUFFER, "ten bit data", 32'hc3);
    rdCheck(OFS_CONTROL, "stop in ninth", 32'h75);
    $display("ten bit done");
  endtask : testTen
  task automatic testEleven();
    logic [10:0] f;
    wr(OFS_CONTROL, 32'h0000_00f8);
    fork
      wr(OFS_BUFFER, 32'h0000_0096);
      rm.recvAsync(11, f);
      rm.sendAsync(11'h422, 11, 32);
    join
    compare("eleven bit frame", 32'h72c, {21'h0, f});
    rdCheck(OFS_CONTROL, "ninth low dropped", 32'hfa);
    rm.sendAsync(11'h6d2, 11, 32);
    waitFlag(BIT_RX_FLAG);
    rdCheck(OFS_BUFFER, "eleven bit data", 32'h69);
    rdCheck(OFS_CONTROL, "ninth bit kept", 32'hff);
    rm.sendAsync(11'h6ee, 11, 32);
    rdCheck(OFS_BUFFER, "flag set blocks", 32'h69);
    $display("eleven bit done");
  endtask : testEleven
  task automatic testGlitch();
    wr(OFS_CONTROL, 32'h0000_0050);
    rm.sendAsync(11'h000, 1, 4);
    rm.sendAsync(11'h7ff, 2, 32);
    rdCheck(OFS_CONTROL, "false start dropped", 32'h50);
    rm.sendAsync(11'h3fe, 10, 32);
    waitFlag(BIT_RX_FLAG);
    rdCheck(OFS_BUFFER, "hunt resumed", 32'hff);
    $display("glitch done");
  endtask : testGlitch
  initial begin
    repeat (100000) @(posedge core_clk);
    errCount++;
    printVerdict();
  end
  initial begin
    errCount = 0;
    nChecks = 0;
    apbReq = '0;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    testRegs();
    testShift();
    testTen();
    testEleven();
    testGlitch();
    printVerdict();
  end
endmodule : test_spfm_top

// file: src/spfm_baud.sv
`timescale 1ns/1ps
module spfm_baud
  import spfm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire spfm_mode_t  mode,
  input  wire logic [16:0] baud,
  output logic [3:0]       phase,
  output logic             tick16
);
  spfm_baud_t baud_reg;
  spfm_baud_t baud_next;

  always_comb begin
    baud_next = baud_reg;
    baud_next.tick16 = 1'b0;
    // twelve phases per machine cycle
    if (baud_reg.phase == PHASE_S6P2) begin
      baud_next.phase = PHASE_S1P1;
    end else begin
      baud_next.phase = baud_reg.phase + 4'h1;
    end
    if (mode == MODE_ELEVEN_FIXED) begin
      baud_next.divCount = 16'h0000;
      baud_next.halfStep = ~baud_reg.halfStep;
      baud_next.tick16   = baud[BIT_BAUD_FAST] | baud_reg.halfStep;
    end else if (baud_reg.divCount >= baud[15:0]) begin
      // overflow of the rate divider stands in for the timer
      baud_next.divCount = 16'h0000;
      baud_next.tick16   = 1'b1;
    end else begin
      baud_next.divCount = baud_reg.divCount + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      baud_reg <= '0;
    end else begin
      baud_reg <= baud_next;
    end
  end

  assign phase  = baud_reg.phase;
  assign tick16 = baud_reg.tick16;
endmodule : spfm_baud

// file: src/spfm_bitdet.sv
`timescale 1ns/1ps
module spfm_bitdet
  import spfm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       rxdIn,
  input  wire logic       tick16,
  input  wire logic [3:0] count,
  output logic            pinLevel,
  output logic            vote
);
  spfm_det_t det_reg;
  spfm_det_t det_next;

  always_comb begin
    det_next = det_reg;
    det_next.sync1 = rxdIn;
    det_next.sync2 = det_reg.sync1;
    if (tick16 && count == VOTE_FIRST) begin
      det_next.firstVote = det_reg.sync2;
    end
    if (tick16 && count == VOTE_SECOND) begin
      det_next.secondVote = det_reg.sync2;
    end
    if (tick16 && count == VOTE_THIRD) begin
      // two of three samples decide
      det_next.vote = (det_reg.firstVote & det_reg.secondVote) |
                      (det_reg.firstVote & det_reg.sync2) |
                      (det_reg.secondVote & det_reg.sync2);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      det_reg <= '1;
    end else begin
      det_reg <= det_next;
    end
  end

  assign pinLevel = det_reg.sync2;
  assign vote     = det_reg.vote;
endmodule : spfm_bitdet

// file: src/spfm_pkg.sv
package spfm_pkg;
  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [31:0] OFS_CONTROL   = 32'h0000_0000;
  localparam logic [31:0] OFS_BUFFER    = 32'h0000_0004;
  localparam logic [31:0] OFS_BAUD      = 32'h0000_0008;
  localparam int          BIT_MODE_LOW  = 7;
  localparam int          BIT_MODE_HIGH = 6;
  localparam int          BIT_MP_ENABLE = 5;
  localparam int          BIT_RX_ENABLE = 4;
  localparam int          BIT_TX_NINTH  = 3;
  localparam int          BIT_RX_NINTH  = 2;
  localparam int          BIT_TX_FLAG   = 1;
  localparam int          BIT_RX_FLAG   = 0;
  localparam int          BIT_BAUD_FAST = 16;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  BUFFER_RESET  = 8'h00;
  localparam logic [16:0] BAUD_RESET    = 17'h00000;
  localparam logic [1:0]  SEL_CONTROL   = 2'h0;
  localparam logic [1:0]  SEL_BUFFER    = 2'h1;
  localparam logic [1:0]  SEL_BAUD      = 2'h2;
  localparam logic [1:0]  SEL_NONE      = 2'h3;

  // ********************************************************
  // timing
  // ********************************************************
  localparam logic [3:0]  PHASE_S1P1    = 4'h0;
  localparam logic [3:0]  PHASE_S3P1    = 4'h4;
  localparam logic [3:0]  PHASE_S5P2    = 4'h9;
  localparam logic [3:0]  PHASE_S6P1    = 4'ha;
  localparam logic [3:0]  PHASE_S6P2    = 4'hb;
  localparam logic [3:0]  DIV_LAST      = 4'hf;
  localparam logic [3:0]  VOTE_FIRST    = 4'h6;
  localparam logic [3:0]  VOTE_SECOND   = 4'h7;
  localparam logic [3:0]  VOTE_THIRD    = 4'h8;
  localparam logic [3:0]  VOTE_USE      = 4'h9;
  localparam logic [8:0]  ASYNC_RX_LOAD = 9'h1ff;
  localparam logic [8:0]  SHIFT_RX_LOAD = 9'h1fe;
  localparam logic [7:0]  TX_MARK       = 8'h01;
  localparam logic [3:0]  BITS_TEN      = 4'h8;
  localparam logic [3:0]  BITS_ELEVEN   = 4'h9;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [1:0] {MODE_SHIFT, MODE_TEN, MODE_ELEVEN_FIXED, MODE_ELEVEN_VAR} spfm_mode_t;
  typedef enum logic [2:0] {TX_IDLE, TX_ARM, TX_WAIT, TX_START, TX_DATA, TX_LAST} spfm_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_ARM, RX_SHIFT, RX_DONE, RX_HUNT, RX_BITS, RX_TAIL
  } spfm_rx_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } spfm_apb_req_t;

  typedef struct packed {
    logic [7:0]  control;
    logic [7:0]  rxBuffer;
    logic [16:0] baud;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    spfm_tx_t    txState;
    logic [8:0]  txShift;
    logic [3:0]  txCount;
    logic [3:0]  txDiv;
    spfm_rx_t    rxState;
    logic [8:0]  rxShift;
    logic [3:0]  rxDiv;
    logic        rxPrev;
    logic        rxSample;
    logic        txd;
    logic        rxdOut;
    logic        rxdOe;
  } spfm_core_t;

  typedef struct packed {
    logic [3:0]  phase;
    logic [15:0] divCount;
    logic        halfStep;
    logic        tick16;
  } spfm_baud_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic firstVote;
    logic secondVote;
    logic vote;
  } spfm_det_t;

  localparam spfm_core_t CORE_RESET = '{control: CONTROL_RESET, rxBuffer: BUFFER_RESET,
                                        baud: BAUD_RESET, txState: TX_IDLE, rxState: RX_IDLE,
                                        txd: 1'b1, rxdOut: 1'b1, rxPrev: 1'b1, default: '0};

  function automatic logic [1:0] spfm_reg_index(input logic [31:0] addr);
    if (addr == OFS_CONTROL) return SEL_CONTROL;
    if (addr == OFS_BUFFER)  return SEL_BUFFER;
    if (addr == OFS_BAUD)    return SEL_BAUD;
    return SEL_NONE;
  endfunction : spfm_reg_index

  function automatic logic [7:0] spfm_reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : spfm_reverse8
endpackage : spfm_pkg

// file: src/spfm_top.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
// How it works
// - mode 0 shifts 8 bits LSB first on the data pin, clock out at clk/12
// - mode 0 buffer write loads marker one, sending starts a machine cycle later
// - mode 0 send clock low S3-S5, high S6-S2, shift right at S6P2
// - zeros enter from left; marker beside MSB ends sending, flag at S1P1
// - mode 0 receive starts with enable set and flag clear, loads 111111110
// - mode 0 receive clock edges S3P1/S6P1, shift in pin sampled at S5P2
// - zero reaching the left end: final shift, buffer load, flag at S1P1
// - mode 1 ten-bit frame, stop bit to received ninth bit, rate from overflow
// - async buffer write loads ninth bit, start after next divide-by-16 rollover
// - start bit first, data bit one bit time later, shifts after that
// - mode 1 sending ends and transmit flag set at tenth rollover
// - modes 2/3 send the ninth bit, end and flag at eleventh rollover
// - async receive sees falling edge at 16x rate, resets counter, loads 1FFH
// - each bit sampled at counter states 6, 7, 8 and voted two of three
// - a start bit that votes high sends the receiver back to hunting
// - mode 1 frame kept only with flag clear and stop bit or no multiprocessor
// - modes 2/3 eleven-bit frames, mode 2 at clk/16 or clk/32
// - modes 2/3 frame kept per flag and ninth bit; hunt again when the counter rolls over from 15
// - mode select bits choose the mode; zero selects the shift mode
module spfm_top
  import spfm_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire spfm_apb_req_t apbReq,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          rxdIn,
  output logic               rxdOut,
  output logic               rxdOe,
  output logic               txd
);
  spfm_core_t core_reg;
  spfm_core_t core_next;
  spfm_mode_t mode;
  logic [3:0] phase;
  logic       tick16;
  logic       pinLevel;
  logic       vote;

  // ********************************************************
  // mode select and timing sources
  // ********************************************************
  assign mode = spfm_mode_t'({core_reg.control[BIT_MODE_LOW],
                              core_reg.control[BIT_MODE_HIGH]});

  spfm_baud u_baud (
    .core_clk (core_clk),
    .reset    (reset),
    .mode     (mode),
    .baud     (core_reg.baud),
    .phase    (phase),
    .tick16   (tick16)
  );

  spfm_bitdet u_bitdet (
    .core_clk (core_clk),
    .reset    (reset),
    .rxdIn    (rxdIn),
    .tick16   (tick16),
    .count    (core_reg.rxDiv),
    .pinLevel (pinLevel),
    .vote     (vote)
  );

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    logic [1:0] sel;
    logic       access;
    logic       wrDone;
    logic       rollTx;
    logic       rxSet;
    logic       txSet;
    logic       ninthLoad;
    logic       shiftActive;
    logic       clockHigh;
    sel         = spfm_reg_index(apbReq.paddr);
    access      = apbReq.psel & apbReq.penable & ~core_reg.pready;
    wrDone      = apbReq.psel & apbReq.penable & core_reg.pready & apbReq.pwrite;
    rollTx      = tick16 & (core_reg.txDiv == DIV_LAST);
    rxSet       = 1'b0;
    txSet       = 1'b0;
    ninthLoad   = 1'b0;
    shiftActive = 1'b0;
    clockHigh   = 1'b1;
    core_next   = core_reg;

    // bus slave, one wait state, error on unmapped
    core_next.pready  = access;
    core_next.pslverr = access & (sel == SEL_NONE);
    if (access) begin
      case (sel)
        SEL_CONTROL: core_next.prdata = {24'h000000, core_reg.control};
        SEL_BUFFER:  core_next.prdata = {24'h000000, core_reg.rxBuffer};
        SEL_BAUD:    core_next.prdata = {15'h0000, core_reg.baud};
        default:     core_next.prdata = 32'h0000_0000;
      endcase
    end

    // ******************************************************
    // transmit path
    // ******************************************************
    if (tick16) begin
      core_next.txDiv = core_reg.txDiv + 4'h1;
    end
    case (core_reg.txState)
      TX_IDLE: begin
      end
      TX_ARM: begin
        if (phase == PHASE_S6P2) begin
          core_next.txState = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (mode == MODE_SHIFT) begin
          if (phase == PHASE_S6P2) begin
            core_next.txState = TX_DATA;
          end
        end else if (rollTx) begin
          core_next.txState = TX_START;
        end
      end
      TX_START: begin
        if (rollTx) begin
          core_next.txState = TX_DATA;
          core_next.txCount = 4'h0;
        end
      end
      TX_DATA: begin
        if (mode == MODE_SHIFT) begin
          if (phase == PHASE_S6P2) begin
            core_next.txShift = {1'b0, core_reg.txShift[8:1]};
            if (core_reg.txShift[8:1] == TX_MARK) begin
              core_next.txState = TX_LAST;
            end
          end
        end else if (rollTx) begin
          core_next.txShift = {1'b0, core_reg.txShift[8:1]};
          core_next.txCount = core_reg.txCount + 4'h1;
          if (mode == MODE_TEN && core_reg.txCount == BITS_TEN - 4'h1) begin
            core_next.txState = TX_IDLE;
            txSet             = 1'b1;
          end else if (mode != MODE_TEN && core_reg.txCount == BITS_ELEVEN - 4'h1) begin
            core_next.txState = TX_IDLE;
            txSet             = 1'b1;
          end
        end
      end
      TX_LAST: begin
        if (phase == PHASE_S1P1) begin
          core_next.txState = TX_IDLE;
          txSet             = 1'b1;
        end
      end
      default: core_next.txState = TX_IDLE;
    endcase
    if (wrDone && sel == SEL_BUFFER) begin
      if (mode == MODE_SHIFT || mode == MODE_TEN) begin
        core_next.txShift = {1'b1, apbReq.pwdata[7:0]};
      end else begin
        core_next.txShift = {core_reg.control[BIT_TX_NINTH], apbReq.pwdata[7:0]};
      end
      core_next.txCount = 4'h0;
      core_next.txState = (mode == MODE_SHIFT) ? TX_ARM : TX_WAIT;
    end

    // ******************************************************
    // receive path
    // ******************************************************
    if (tick16) begin
      core_next.rxPrev = pinLevel;
    end
    case (core_reg.rxState)
      RX_IDLE: begin
        if (core_reg.control[BIT_RX_ENABLE]) begin
          if (mode != MODE_SHIFT) begin
            core_next.rxState = RX_HUNT;
          end else if (!core_reg.control[BIT_RX_FLAG]) begin
            core_next.rxState = RX_ARM;
          end
        end
      end
      RX_ARM: begin
        if (phase == PHASE_S6P2) begin
          core_next.rxShift = SHIFT_RX_LOAD;
          core_next.rxState = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (phase == PHASE_S5P2) begin
          core_next.rxSample = pinLevel;
        end
        if (phase == PHASE_S6P1) begin
          core_next.rxShift = {core_reg.rxShift[7:0], core_reg.rxSample};
          if (!core_reg.rxShift[7]) begin
            // first sample lands in the buffer's bit 0
            core_next.rxBuffer = spfm_reverse8({core_reg.rxShift[6:0],
                                                core_reg.rxSample});
            core_next.rxState  = RX_DONE;
          end
        end
      end
      RX_DONE: begin
        if (phase == PHASE_S1P1) begin
          rxSet             = 1'b1;
          core_next.rxState = RX_IDLE;
        end
      end
      RX_HUNT: begin
        if (tick16 && core_reg.rxPrev && !pinLevel) begin
          core_next.rxDiv   = 4'h0;
          core_next.rxShift = ASYNC_RX_LOAD;
          core_next.rxState = RX_BITS;
        end
      end
      RX_BITS: begin
        if (tick16) begin
          core_next.rxDiv = core_reg.rxDiv + 4'h1;
          if (core_reg.rxDiv == VOTE_USE) begin
            if (core_reg.rxShift == ASYNC_RX_LOAD) begin
              if (vote) begin
                core_next.rxState = RX_HUNT;
              end else begin
                core_next.rxShift = {vote, core_reg.rxShift[8:1]};
              end
            end else if (!core_reg.rxShift[0]) begin
              // start bit at the far end: this is the stop or ninth bit
              if (!core_reg.control[BIT_RX_FLAG] &&
                  (!core_reg.control[BIT_MP_ENABLE] || vote)) begin
                core_next.rxBuffer = core_reg.rxShift[8:1];
                ninthLoad          = 1'b1;
                rxSet              = 1'b1;
              end
              core_next.rxState = (mode == MODE_TEN) ? RX_HUNT : RX_TAIL;
            end else begin
              core_next.rxShift = {vote, core_reg.rxShift[8:1]};
            end
          end
        end
      end
      RX_TAIL: begin
        if (tick16) begin
          core_next.rxDiv = core_reg.rxDiv + 4'h1;
          if (core_reg.rxDiv == DIV_LAST) begin
            core_next.rxState = RX_HUNT;
          end
        end
      end
      default: core_next.rxState = RX_IDLE;
    endcase
    if (!core_reg.control[BIT_RX_ENABLE] &&
        (core_reg.rxState == RX_HUNT || core_reg.rxState == RX_ARM)) begin
      core_next.rxState = RX_IDLE;
    end

    // ******************************************************
    // register writes; hardware sets win over software
    // ******************************************************
    if (wrDone && sel == SEL_CONTROL) begin
      core_next.control = apbReq.pwdata[7:0];
    end
    if (wrDone && sel == SEL_BAUD) begin
      core_next.baud = apbReq.pwdata[16:0];
    end
    if (txSet) begin
      core_next.control[BIT_TX_FLAG] = 1'b1;
    end
    if (rxSet) begin
      core_next.control[BIT_RX_FLAG] = 1'b1;
    end
    if (ninthLoad) begin
      core_next.control[BIT_RX_NINTH] = vote;
    end

    // ******************************************************
    // pins
    // ******************************************************
    clockHigh   = (phase < PHASE_S3P1) || (phase > PHASE_S5P2);
    shiftActive = (core_next.txState == TX_DATA) || (core_next.txState == TX_LAST) ||
                  (core_next.rxState == RX_SHIFT);
    if (mode == MODE_SHIFT) begin
      core_next.txd    = shiftActive ? clockHigh : 1'b1;
      core_next.rxdOe  = (core_next.txState == TX_DATA) ||
                         (core_next.txState == TX_LAST);
      core_next.rxdOut = core_next.rxdOe ? core_next.txShift[0] : 1'b1;
    end else begin
      core_next.rxdOe  = 1'b0;
      core_next.rxdOut = 1'b1;
      if (core_next.txState == TX_START) begin
        core_next.txd = 1'b0;
      end else if (core_next.txState == TX_DATA) begin
        core_next.txd = core_next.txShift[0];
      end else begin
        core_next.txd = 1'b1;
      end
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      core_reg <= CORE_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  assign pready  = core_reg.pready;
  assign prdata  = core_reg.prdata;
  assign pslverr = core_reg.pslverr;
  assign txd     = core_reg.txd;
  assign rxdOut  = core_reg.rxdOut;
  assign rxdOe   = core_reg.rxdOe;
endmodule : spfm_top
